// File: rtl/irqdma_regs.vh
`ifndef IRQDMA_REGS_VH
`define IRQDMA_REGS_VH
// Configuration register indices
`define IRQDMA_IDX_LDN 8'h07
`define IRQDMA_IDX_OSC 8'h24
`define IRQDMA_IDX_CFG_LO 8'h26
`define IRQDMA_IDX_CFG_HI 8'h27
`define IRQDMA_IDX_ACT 8'h30
`define IRQDMA_IDX_BASE_HI 8'h60
`define IRQDMA_IDX_BASE_LO 8'h61
`define IRQDMA_IDX_IRQ 8'h70
`define IRQDMA_IDX_DMA 8'h74
// Logical device numbers
`define IRQDMA_LD_FDC 4'h0
`define IRQDMA_LD_PP 4'h3
`define IRQDMA_LD_SP1 4'h4
`define IRQDMA_LD_SP2 4'h5
// Reset values
`define IRQDMA_IRQ_RST 8'h00
`define IRQDMA_IRQ_RST_FDC 8'h06
`define IRQDMA_DMA_RST_FDC 8'h02
`define IRQDMA_DMA_RST_PP 8'h04
`define IRQDMA_CFG_PORT0 16'h002e
`define IRQDMA_CFG_PORT1 16'h004e
// Field positions
`define IRQDMA_OSC_QUAL_BIT 6
`define IRQDMA_SMI_CODE 4'h2
`define IRQDMA_DMA_MAX 3'h3
// Parallel extended modes; the interrupt is forced on in FIFO, ECP and TEST only
`define IRQDMA_ECR_FIFO 3'h2
`define IRQDMA_ECR_ECP 3'h3
`define IRQDMA_ECR_TEST 3'h6
`define IRQDMA_ECR_EPP 3'h4
`endif

// File: rtl/irqdma_route.v
// Operation
// R1: Base decode compares address bits 11 to 3
// R2: Qualify bit also requires top nibble zero
// R3: Config port strap-selected, relocatable by registers
// R4: Interrupt select low nibble picks line
// R5: Software disables SMI before using line 2
// R6: Routed interrupts active high; SMI low
// R7: Interrupt select resets zero, floppy six
// R8: Interrupt needs nonzero code plus local enable
// R9: Extended mode needs service bit clear
// R10: Serial interrupt needs enable bits and aux two
// R11: Unselected interrupt lines stay disabled
// R12: All fifteen lines reportable in serial mode
// R13: DMA select low three bits choose channel
// R14: DMA select resets two floppy, four others
// R15: DMA active needs code 1-3 plus enable
// R16: Unselected DMA channels stay disabled
// R17: Inactive or invalid base disables routing
// R18: Floppy gated by dma gate and power
// R19: Second serial DMA needs own enable
// R20: Standard modes gate interrupt by control bit
// R21: Extended modes: dma gate, forced interrupt
// R22: Index at port, data at port plus one
`timescale 1ns/1ns
`default_nettype none
`include "irqdma_regs.vh"
module irqdma_route (
   // Clock and reset
   input wire clk_sys,
   input wire rst_b,
   input wire soft_reset,
   input wire config_port_strap,
   // Host I/O cycle
   input wire [15:0] io_addr,
   input wire io_wr,
   input wire io_rd,
   input wire [7:0] io_wdata,
   output reg [7:0] io_rdata,
   output wire io_cfg_hit,
   output wire [3:0] ld_decode_hit,
   // Local enables from the functions
   input wire [7:0] floppy_digital_output_reg,
   input wire floppy_powered_down,
   input wire [7:0] printer_control_reg,
   input wire [7:0] ecp_ext_control_reg,
   input wire ecp_mode_active,
   input wire [7:0] uart1_int_enable_reg,
   input wire [7:0] uart1_modem_control_reg,
   input wire [7:0] uart2_int_enable_reg,
   input wire [7:0] uart2_modem_control_reg,
   input wire uart2_dma_enable,
   // Function requests
   input wire floppy_irq_req,
   input wire printer_irq_req,
   input wire uart1_irq_req,
   input wire uart2_irq_req,
   input wire floppy_drq,
   input wire printer_drq,
   input wire uart2_drq,
   // Routed outputs toward the host chipset
   output reg [15:1] irq_out,
   output reg system_mgmt_int_n,
   output reg [3:1] drq_out,
   output reg [15:1] serirq_frame
);
   // Per-device storage, four devices: floppy, printer, uart1, uart2
   reg [7:0] irq_sel [0:3];
   reg [7:0] dma_sel [0:3];
   reg [3:0] active;
   reg [11:0] base [0:3];
   reg [7:0] osc_cfg;
   reg [15:0] cfg_port;
   reg [7:0] cfg_index;
   reg [3:0] ldn;
   reg strap_taken;
   reg [1:0] slot;
   reg slot_ok;
   integer i;

   // Map logical device number to storage slot
   always @* begin
      slot = 2'd0;
      slot_ok = 1'b1;
      case (ldn)
         `IRQDMA_LD_FDC: slot = 2'd0;
         `IRQDMA_LD_PP: slot = 2'd1;
         `IRQDMA_LD_SP1: slot = 2'd2;
         `IRQDMA_LD_SP2: slot = 2'd3;
         default: slot_ok = 1'b0;
      endcase
   end

   // Reset value helpers, used by soft reset
   function [7:0] irq_rst;
      input [1:0] s;
      irq_rst = (s == 2'd0) ? `IRQDMA_IRQ_RST_FDC : `IRQDMA_IRQ_RST; // see R7
   endfunction
   function [7:0] dma_rst;
      input [1:0] s;
      dma_rst = (s == 2'd0) ? `IRQDMA_DMA_RST_FDC : `IRQDMA_DMA_RST_PP; // see R14
   endfunction

   // Address decode of a base; top nibble checked only when qualified
   function dec_hit;
      input [15:0] a;
      input [11:0] b;
      input qual;
      dec_hit = (a[11:3] == b[11:3]) && (b != 12'h000) && // see R1
         (!qual || a[15:12] == 4'h0); // see R2
   endfunction

   wire qual = osc_cfg[`IRQDMA_OSC_QUAL_BIT];
   // Config port pair: index at port, data at port plus one
   assign io_cfg_hit = (io_addr[15:1] == cfg_port[15:1]); // see R22
   wire data_acc = io_cfg_hit && io_addr[0];

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_dec
         assign ld_decode_hit[g] = active[g] && dec_hit(io_addr, base[g], qual);
      end
   endgenerate

   // Configuration registers; soft reset restores routing registers
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         for (i = 0; i < 4; i = i + 1) begin
            irq_sel[i] <= (i == 0) ? `IRQDMA_IRQ_RST_FDC : `IRQDMA_IRQ_RST;
            dma_sel[i] <= (i == 0) ? `IRQDMA_DMA_RST_FDC : `IRQDMA_DMA_RST_PP;
            base[i] <= 12'h000;
         end
         active <= 4'h0;
         osc_cfg <= 8'h00;
         cfg_port <= `IRQDMA_CFG_PORT0;
         strap_taken <= 1'b0;
         cfg_index <= 8'h00;
         ldn <= 4'h0;
      end else if (!strap_taken) begin
         // Strap caught on first clock after release
         strap_taken <= 1'b1;
         cfg_port <= config_port_strap ? `IRQDMA_CFG_PORT1 : `IRQDMA_CFG_PORT0; // see R3
      end else if (soft_reset) begin
         for (i = 0; i < 4; i = i + 1) begin
            irq_sel[i] <= irq_rst(i[1:0]);
            dma_sel[i] <= dma_rst(i[1:0]);
         end
      end else if (io_wr && io_cfg_hit && !io_addr[0]) begin
         cfg_index <= io_wdata; // see R22
      end else if (io_wr && data_acc) begin
         case (cfg_index)
            `IRQDMA_IDX_LDN: ldn <= io_wdata[3:0];
            `IRQDMA_IDX_OSC: osc_cfg <= io_wdata;
            // Relocation of the config port
            `IRQDMA_IDX_CFG_LO: cfg_port[7:0] <= io_wdata; // see R3
            `IRQDMA_IDX_CFG_HI: cfg_port[15:8] <= io_wdata; // see R3
            `IRQDMA_IDX_ACT: if (slot_ok) active[slot] <= io_wdata[0];
            `IRQDMA_IDX_BASE_HI: if (slot_ok) base[slot][11:8] <= io_wdata[3:0];
            `IRQDMA_IDX_BASE_LO: if (slot_ok) base[slot][7:0] <= io_wdata;
            `IRQDMA_IDX_IRQ: if (slot_ok) irq_sel[slot] <= io_wdata;
            // Uart1 only has no DMA here; printer and uart2 do
            `IRQDMA_IDX_DMA: if (slot_ok) dma_sel[slot] <= io_wdata;
            default: ;
         endcase
      end
   end

   // Read data from flops; unmapped indices read zero
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         io_rdata <= 8'h00;
      end else if (io_rd && io_cfg_hit && !io_addr[0]) begin
         io_rdata <= cfg_index;
      end else if (io_rd && data_acc) begin
         case (cfg_index)
            `IRQDMA_IDX_LDN: io_rdata <= {4'h0, ldn};
            `IRQDMA_IDX_OSC: io_rdata <= osc_cfg;
            `IRQDMA_IDX_CFG_LO: io_rdata <= cfg_port[7:0];
            `IRQDMA_IDX_CFG_HI: io_rdata <= cfg_port[15:8];
            `IRQDMA_IDX_ACT: io_rdata <= slot_ok ? {7'h00, active[slot]} : 8'h00;
            `IRQDMA_IDX_BASE_HI:
               io_rdata <= slot_ok ? {4'h0, base[slot][11:8]} : 8'h00;
            `IRQDMA_IDX_BASE_LO: io_rdata <= slot_ok ? base[slot][7:0] : 8'h00;
            `IRQDMA_IDX_IRQ: io_rdata <= slot_ok ? irq_sel[slot] : 8'h00;
            `IRQDMA_IDX_DMA: io_rdata <= slot_ok ? dma_sel[slot] : 8'h00;
            default: io_rdata <= 8'h00;
         endcase
      end
   end

   // Configuration-level gate: activated with a valid base
   function cfg_gate;
      input act;
      input [11:0] b;
      cfg_gate = act && (b != 12'h000); // see R17
   endfunction

   // DMA code valid range
   function dma_ok;
      input [7:0] s;
      dma_ok = (s[2:0] != 3'h0) && (s[2:0] <= `IRQDMA_DMA_MAX); // see R13
   endfunction

   // Local gates from the functions
   wire [2:0] ecr_mode = ecp_ext_control_reg[7:5];
   wire ecr_forced = (ecr_mode == `IRQDMA_ECR_FIFO) ||
      (ecr_mode == `IRQDMA_ECR_ECP) || (ecr_mode == `IRQDMA_ECR_TEST);
   wire floppy_dma_gate = floppy_digital_output_reg[3];
   wire printer_irq_gate = printer_control_reg[4];
   wire ecp_service_int_mask = ecp_ext_control_reg[2];
   wire ecp_dma_gate = ecp_ext_control_reg[3];
   wire fdc_ok = floppy_dma_gate && !floppy_powered_down; // see R18
   // Printer interrupt: forced in fifo/ecp/test, else control bit
   wire pp_irq_ok = ecp_mode_active ?
      ((ecr_forced || printer_irq_gate) && !ecp_service_int_mask) : // see R9
      printer_irq_gate; // see R20
   // Serial: any low enable bit and aux output two
   wire sp1_ok = (|uart1_int_enable_reg[3:0]) && uart1_modem_control_reg[2]; // see R10
   wire sp2_ok = (|uart2_int_enable_reg[3:0]) && uart2_modem_control_reg[2]; // see R10

   reg [3:0] irq_en;
   reg [3:0] dma_en;
   reg [3:0] irq_req;
   reg [3:0] dma_req;
   reg [15:1] next_irq;
   reg [3:1] next_drq;
   reg next_smi;
   integer d;

   // Per-device enables, then OR onto selected lines
   always @* begin
      irq_req = {uart2_irq_req, uart1_irq_req, printer_irq_req, floppy_irq_req};
      dma_req = {uart2_drq, 1'b0, printer_drq, floppy_drq};
      irq_en[0] = fdc_ok; // see R8
      irq_en[1] = pp_irq_ok; // see R8
      irq_en[2] = sp1_ok;
      irq_en[3] = sp2_ok;
      dma_en[0] = fdc_ok; // see R15
      dma_en[1] = ecp_mode_active && ecp_dma_gate; // see R21
      dma_en[2] = 1'b0;
      dma_en[3] = uart2_dma_enable; // see R19
      next_irq = 15'h0000;
      next_drq = 3'h0;
      next_smi = 1'b1;
      for (d = 0; d < 4; d = d + 1) begin
         if (cfg_gate(active[d], base[d]) && irq_en[d] && irq_req[d] &&
               irq_sel[d][3:0] != 4'h0) begin // see R4
            next_irq[irq_sel[d][3:0]] = 1'b1; // see R11
         end
         if (cfg_gate(active[d], base[d]) && dma_en[d] && dma_req[d] &&
               dma_ok(dma_sel[d])) begin
            next_drq[dma_sel[d][1:0]] = 1'b1; // see R16
         end
      end
      // Code two also drives the low-active management line; software
      // must have the management interrupt off when line 2 is assigned
      if (next_irq[`IRQDMA_SMI_CODE]) begin // see R5
         next_smi = 1'b0; // see R6
      end
   end

   // Registered outputs, active-high lines, serial frame mirror
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         irq_out <= 15'h0000;
         drq_out <= 3'h0;
         system_mgmt_int_n <= 1'b1;
         serirq_frame <= 15'h0000;
      end else begin
         irq_out <= next_irq; // see R6
         drq_out <= next_drq;
         system_mgmt_int_n <= next_smi;
         serirq_frame <= next_irq; // see R12
      end
   end
endmodule // irqdma_route
`default_nettype wire

// File: sim/irqdma_properties.sv
`timescale 1ns/1ns
`default_nettype none
module irqdma_properties (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Local enables
   input wire logic [7:0] floppy_digital_output_reg,
   input wire logic floppy_powered_down,
   input wire logic [7:0] printer_control_reg,
   input wire logic [7:0] ecp_ext_control_reg,
   input wire logic ecp_mode_active,
   input wire logic [7:0] uart1_modem_control_reg,
   input wire logic uart2_dma_enable,
   // Requests
   input wire logic floppy_irq_req,
   input wire logic printer_irq_req,
   input wire logic uart1_irq_req,
   input wire logic uart2_irq_req,
   input wire logic floppy_drq,
   input wire logic printer_drq,
   input wire logic uart2_drq,
   // Routed outputs
   input wire logic [15:1] irq_out,
   input wire logic system_mgmt_int_n,
   input wire logic [3:1] drq_out
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   // No line and no management interrupt driven
   wire irq_quiet = irq_out == 15'h0000 && system_mgmt_int_n;
   // Request mixes, one edge each
   sequence s_no_irq;
      !(floppy_irq_req | printer_irq_req | uart1_irq_req | uart2_irq_req);
   endsequence
   sequence s_pp_irq;
      printer_irq_req && !(floppy_irq_req | uart1_irq_req | uart2_irq_req);
   endsequence
   sequence s_fdc_only;
      !(printer_irq_req | uart1_irq_req | uart2_irq_req | printer_drq | uart2_drq);
   endsequence
   property p_idle_irq;
      s_no_irq |=> irq_quiet;
   endproperty
   a_idle_irq: assert property (p_idle_irq) else $error("irq without request");
   property p_idle_dma;
      !(floppy_drq | printer_drq | uart2_drq) |=> drq_out == 3'h0;
   endproperty
   a_idle_dma: assert property (p_idle_dma) else $error("drq without request");
   property p_fdc_gate;
      s_fdc_only ##0 (!floppy_digital_output_reg[3] || floppy_powered_down)
         |=> irq_quiet && drq_out == 3'h0;
   endproperty
   a_fdc_gate: assert property (p_fdc_gate) else $error("floppy not gated");
   property p_uart_aux;
      uart1_irq_req && !(floppy_irq_req | printer_irq_req | uart2_irq_req)
         && !uart1_modem_control_reg[2] |=> irq_quiet;
   endproperty
   a_uart_aux: assert property (p_uart_aux) else $error("serial not gated");
   property p_pp_ctrl;
      s_pp_irq ##0 !ecp_mode_active && !printer_control_reg[4] |=> irq_quiet;
   endproperty
   a_pp_ctrl: assert property (p_pp_ctrl) else $error("printer not gated");
   property p_pp_svc;
      s_pp_irq ##0 ecp_mode_active && ecp_ext_control_reg[2] |=> irq_quiet;
   endproperty
   a_pp_svc: assert property (p_pp_svc) else $error("service bit ignored");
   property p_sp2_dma;
      uart2_drq && !uart2_dma_enable && !(floppy_drq | printer_drq)
         |=> drq_out == 3'h0;
   endproperty
   a_sp2_dma: assert property (p_sp2_dma) else $error("uart dma not gated");
   property p_one_line;
      $onehot({floppy_irq_req, printer_irq_req, uart1_irq_req, uart2_irq_req})
         |=> $onehot0(irq_out);
   endproperty
   a_one_line: assert property (p_one_line) else $error("several lines");
endmodule // irqdma_properties
bind irqdma_route irqdma_properties u_props (.*);
`default_nettype wire

// File: sim/irqdma_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// Host controller side: counts rising edges of routed lines
module irqdma_host_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Lines from the routing block
   input wire logic [15:1] irq_out,
   // Edges accepted so far
   output logic [15:0] irq_edges
);
   logic [15:1] irq_last; // Level at previous edge
   // Only low-to-high counts, a held level is one request
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         irq_last <= 15'h0000;
         irq_edges <= 16'h0000;
      end else begin
         irq_last <= irq_out;
         irq_edges <= irq_edges + 16'($countones(irq_out & ~irq_last));
      end
   end
endmodule // irqdma_host_model
`default_nettype wire

// File: sim/irqdma_route_tb.sv
`timescale 1ns/1ns
`default_nettype none
module irqdma_route_tb;
   // Stimulus, idle at time zero; strap and second uart irq tied
   logic clk_sys = 1'b0, rst_b = 1'b0, soft_reset = 1'b0, io_wr = 1'b0;
   logic io_rd = 1'b0, config_port_strap = 1'b0, floppy_powered_down = 1'b0;
   logic ecp_mode_active = 1'b0, uart2_dma_enable = 1'b0, floppy_drq = 1'b0;
   logic floppy_irq_req = 1'b0, printer_irq_req = 1'b0, uart1_irq_req = 1'b0;
   logic uart2_irq_req = 1'b0, printer_drq = 1'b0, uart2_drq = 1'b0;
   logic [15:0] io_addr = 16'h0000;
   logic [7:0] io_wdata = 8'h00, floppy_digital_output_reg = 8'h00;
   logic [7:0] printer_control_reg = 8'h00, ecp_ext_control_reg = 8'h00;
   logic [7:0] uart1_int_enable_reg = 8'h00, uart1_modem_control_reg = 8'h00;
   logic [7:0] uart2_int_enable_reg = 8'h00, uart2_modem_control_reg = 8'h00;
   // Outputs
   wire [7:0] io_rdata;
   wire io_cfg_hit, system_mgmt_int_n;
   wire [3:0] ld_decode_hit;
   wire [15:1] irq_out, serirq_frame;
   wire [3:1] drq_out;
   wire [15:0] irq_edges;
   // Expectation notes and their strobes
   logic [7:0] q_rd[$];
   logic [37:0] q_rt[$];
   logic rd_v = 1'b0, rt_v = 1'b0;
   int error_cnt = 0, tests_run = 0, i;
   integer seed = 32'h16ac121c, r;
   irqdma_route u_dut (.*);
   irqdma_host_model u_host (.*);
   always #4 clk_sys = ~clk_sys;
   // One host cycle, held across one sampling edge
   task io(input logic w, input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_sys) #1;
      io_wr = w;
      io_rd = !w;
      io_addr = a;
      io_wdata = d;
      @(posedge clk_sys) #1;
      io_wr = 1'b0;
      io_rd = 1'b0;
   endtask
   // Index then data
   task cw(input logic [7:0] x, input logic [7:0] d);
      io(1'b1, 16'h002e, x);
      io(1'b1, 16'h002f, d);
   endtask
   // Strobe the monitor once results have settled
   task note(input logic k);
      @(posedge clk_sys) #1;
      rd_v = !k;
      rt_v = k;
      @(posedge clk_sys) #1;
      rd_v = 1'b0;
      rt_v = 1'b0;
   endtask
   task cr(input logic [7:0] x, input logic [7:0] e);
      io(1'b1, 16'h002e, x);
      io(1'b0, 16'h002f, 8'h00);
      q_rd.push_back(e);
      note(1'b0);
   endtask
   // Mask lets the shared line two case check only the management and DMA outputs
   task rt(input logic [18:0] e, input logic [18:0] m = 19'h7ffff);
      @(posedge clk_sys);
      q_rt.push_back({e, m});
      note(1'b1);
   endtask
   // Enable logical device n with a line and a channel code
   task dev(input logic [7:0] n, input logic [7:0] q, input logic [7:0] c);
      cw(8'h07, n);
      cw(8'h30, 8'h01);
      cw(8'h60, 8'h03);
      cw(8'h61, {n[3:0], 4'h8});
      cw(8'h70, q);
      cw(8'h74, c);
   endtask
   // Expected {smi_n, drq, irq} for line l and channel d
   function logic [18:0] ex(input logic [3:0] l, input logic [1:0] d);
      ex = {l != 4'h2, d != 2'h0 ? 3'h1 << (d - 2'h1) : 3'h0,
         l != 4'h0 ? 15'h1 << (l - 4'h1) : 15'h0000};
   endfunction
   // Decode hit is combinational; look once the address has settled
   task hit(input logic [15:0] a, input logic [3:0] e);
      @(posedge clk_sys) #1;
      io_addr = a;
      #1;
      tests_run++;
      if (ld_decode_hit !== e) begin
         error_cnt++;
         $display("mismatch ld_decode_hit exp %h seen %h", e, ld_decode_hit);
      end
   endtask
   task chk_rd(input logic [7:0] e);
      tests_run++;
      if (io_rdata !== e) begin
         error_cnt++;
         $display("mismatch io_rdata exp %h seen %h", e, io_rdata);
      end
   endtask
   // Serial frame must mirror the routed lines
   task chk_rt(input logic [37:0] e);
      logic [33:0] m, s, x;
      m = {e[14:0], e[18:0]};
      s = {serirq_frame, system_mgmt_int_n, drq_out, irq_out} & m;
      x = {e[33:19], e[37:19]} & m;
      tests_run++;
      if (s !== x) begin
         error_cnt++;
         $display("mismatch routing exp %h seen %h", x, s);
      end
   endtask
   // Monitor takes the oldest note per strobe
   always @(negedge clk_sys) begin
      if (rd_v) chk_rd(q_rd.pop_front());
      if (rt_v) chk_rt(q_rt.pop_front());
   end
   task results;
      $display("checks %0d mismatches %0d edges %0d", tests_run, error_cnt,
         irq_edges);
      if (error_cnt == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Watchdog, run needs well under this
   initial begin
      #300000;
      error_cnt++;
      results;
   end
   initial begin
      repeat (3) @(posedge clk_sys);
      #1 rst_b = 1'b1;
      for (i = 0; i < 3; i++) begin
         cw(8'h07, i == 0 ? 8'h00 : i == 1 ? 8'h03 : 8'h05);
         cr(8'h70, i == 0 ? 8'h06 : 8'h00);
         cr(8'h74, i == 0 ? 8'h02 : 8'h04);
      end
      $display("reset values done");
      floppy_digital_output_reg = 8'h08;
      floppy_irq_req = 1'b1;
      floppy_drq = 1'b1;
      dev(8'h00, 8'h00, 8'h02);
      hit(16'h130a, 4'h1);
      cw(8'h24, 8'h40);
      hit(16'h130a, 4'h0);
      hit(16'h030a, 4'h1);
      cw(8'h24, 8'h00);
      for (i = 1; i < 16; i++) begin
         cw(8'h70, i[7:0]);
         rt(ex(i[3:0], 2'h2), i == 2 ? 19'h78000 : 19'h7ffff);
      end
      cw(8'h70, 8'h03);
      repeat (8) begin
         r = $random(seed);
         cw(8'h74, {5'h00, r[2:0]});
         rt(ex(4'h3, r[2] ? 2'h0 : r[1:0]));
      end
      soft_reset = 1'b1;
      @(posedge clk_sys) #1;
      soft_reset = 1'b0;
      cr(8'h70, 8'h06);
      cr(8'h74, 8'h02);
      floppy_digital_output_reg = 8'hf7;
      rt(ex(4'h0, 2'h0));
      floppy_digital_output_reg = 8'h08;
      floppy_powered_down = 1'b1;
      rt(ex(4'h0, 2'h0));
      floppy_powered_down = 1'b0;
      cw(8'h30, 8'h00);
      rt(ex(4'h0, 2'h0));
      cw(8'h30, 8'h01);
      rt(ex(4'h6, 2'h2));
      floppy_irq_req = 1'b0;
      floppy_drq = 1'b0;
      $display("floppy done");
      dev(8'h04, 8'h04, 8'h04);
      uart1_irq_req = 1'b1;
      uart1_modem_control_reg = 8'h04;
      rt(ex(4'h0, 2'h0));
      r = $random(seed);
      uart1_int_enable_reg = {r[7:4], r[3:0] | 4'h1};
      rt(ex(4'h4, 2'h0));
      uart1_modem_control_reg = 8'hfb;
      rt(ex(4'h0, 2'h0));
      uart1_irq_req = 1'b0;
      $display("serial done");
      dev(8'h03, 8'h07, 8'h01);
      printer_irq_req = 1'b1;
      printer_drq = 1'b1;
      printer_control_reg = 8'h10;
      rt(ex(4'h7, 2'h0));
      printer_control_reg = 8'hef;
      rt(ex(4'h0, 2'h0));
      ecp_mode_active = 1'b1;
      for (i = 0; i < 8; i++) begin
         ecp_ext_control_reg = {i[2:0], 5'h08};
         rt(ex(i == 2 || i == 3 || i == 6 ? 4'h7 : 4'h0, 2'h1));
      end
      ecp_ext_control_reg = 8'h64;
      rt(ex(4'h0, 2'h0));
      printer_irq_req = 1'b0;
      printer_drq = 1'b0;
      $display("parallel done");
      dev(8'h05, 8'h00, 8'h03);
      uart2_drq = 1'b1;
      rt(ex(4'h0, 2'h0));
      uart2_dma_enable = 1'b1;
      rt(ex(4'h0, 2'h3));
      $display("uart dma done");
      results;
   end
endmodule // irqdma_route_tb
`default_nettype wire
